// File: shared/fbu_defines.vh
// constants for the fieldbus link entity: sizes, widths, status codes
// assumes inclusion by bare name from every design file
`ifndef FBU_DEFINES_VH
`define FBU_DEFINES_VH

`define FBU_EP_W      4
`define FBU_EPS       16
`define FBU_ID_W      16
`define FBU_MEM_AW    12
`define FBU_LST_AW    10
`define FBU_BUF_MAX   8'h80
`define FBU_LIST_MAX  7'h40
`define FBU_QDEPTH    64
`define FBU_QFRAME    8'h40

`define FBU_ST_OK        3'h0
`define FBU_ST_UNKNOWN   3'h1
`define FBU_ST_INVALID   3'h2
`define FBU_ST_CONFLICT  3'h3
`define FBU_ST_OVERRIDE  3'h4
`define FBU_ST_QFULL     3'h5
`define FBU_ST_SIZE      3'h6

`endif

// File: testbench/fbu_link_entity_chk.sv
// checker for fbu_link_entity: reads, notices, request frames
// assumes one clock domain
`timescale 1ns/10ps
`include "fbu_defines.vh"
module fbu_link_chk (
  input logic       clk,
  input logic       rstn,
  input logic       buffer_read_request,
  input logic       rd_ready,
  input logic       rd_data_valid,
  input logic       rd_done,
  input logic [2:0] rd_status,
  input logic       link_rx_valid,
  input logic [3:0] link_rx_ep,
  input logic       link_rx_last,
  input logic       link_rx_ok,
  input logic       variable_received_notice,
  input logic [3:0] received_ep,
  input logic       tx_valid,
  input logic       tx_last,
  input logic       variable_sent_notice,
  input logic       rq_valid,
  input logic       rq_last,
  input logic       sp_done,
  input logic [2:0] sp_status,
  input logic       fr_done,
  input logic [2:0] fr_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [6:0] rq_cnt_reg;
  // ids so far in this frame
  always @(posedge clk or negedge rstn)
    if (!rstn)
      rq_cnt_reg <= 7'h00;
    else if (rq_valid)
      rq_cnt_reg <= rq_last ? 7'h00 : rq_cnt_reg + 7'h01;
////////////////////////////////////////////////////////////////////////////////
  AST_RD_DONE: assert property (buffer_read_request && rd_ready |-> ##[1:130] rd_done)
    else $error("read without completion");
  AST_RD_ERR: assert property (rd_done && rd_status != `FBU_ST_OK
    && rd_status != `FBU_ST_CONFLICT |-> !rd_data_valid)
    else $error("failed read carried data");
  AST_RD_CODE: assert property (rd_done |-> rd_status <= `FBU_ST_CONFLICT)
    else $error("read status out of set");
  AST_RD_STREAM: assert property (rd_data_valid && !rd_done |=> rd_data_valid)
    else $error("read data stream broke");
  AST_RX_NOTE: assert property (variable_received_notice |->
    $past(link_rx_valid && link_rx_last && link_rx_ok) && received_ep == $past(link_rx_ep))
    else $error("notice without good frame");
  AST_SENT: assert property (variable_sent_notice |-> tx_valid && tx_last)
    else $error("sent notice off last byte");
  AST_FR_OK: assert property (fr_done && fr_status == `FBU_ST_OK |-> rq_valid)
    else $error("free done outside frame");
  AST_SP_OK: assert property (sp_done && sp_status == `FBU_ST_OK |-> rq_valid && rq_last)
    else $error("spec done off frame end");
  AST_RQ_MAX: assert property (rq_valid |-> rq_cnt_reg < 7'h40)
    else $error("request frame too long");
  AST_RQ_RUN: assert property (rq_valid && !rq_last |=> rq_valid)
    else $error("request frame split");
  cover property (rd_done && rd_status == `FBU_ST_OK);
  cover property (variable_sent_notice);
  cover property (sp_done && sp_status == `FBU_ST_OVERRIDE);
endmodule
bind fbu_link_entity fbu_link_chk u_chk (.*);

// File: testbench/fbu_link_entity_tb.sv
// self-checking bench: reception, reads, emission, update requests
// assumes the link model on the bus side
`timescale 1ns/10ps
`include "fbu_defines.vh"
module fbu_link_entity_tb;
  logic        clk = 1'b0, rstn = 1'b0, cfg_we = 1'b0, cfg_known, cfg_valid, cfg_spec;
  logic        cfg_publish, cfg_periodic, wr_last, sp_last, fr_last, fr_urgent, rq_aperiodic;
  logic        buffer_write_request = 1'b0, buffer_read_request = 1'b0;
  logic        specified_update_request = 1'b0, free_update_request = 1'b0;
  logic [3:0]  cfg_ep, wr_ep, rd_ep, sp_ep, received_ep, sent_ep, link_rx_ep, link_tx_ep;
  logic [4:0]  seen = '0;
  logic [7:0]  wr_byte, rd_data, tx_byte, link_rx_byte, tx_seen;
  logic [15:0] sp_id, fr_id, rq_id, rd_got;
  logic [2:0]  wr_status, rd_status, sp_status, fr_status;
  logic        rd_data_valid, rd_done, variable_received_notice, tx_valid, rq_valid, rq_last;
  logic        variable_sent_notice, sp_done, fr_done, link_rx_valid, link_rx_last;
  logic        link_rx_ok, link_tx_req;
  logic [15:0] rq_q[$];
  int          mismatches, n_compared, n_fr;
  always #2 clk = ~clk;
  fbu_link_entity u_dut (.*, .wr_done(), .rd_ready(), .tx_last(), .tx_none(),
    .sp_ready(), .sp_done_ep(), .fr_ready(), .fr_done_urgent());
  fbu_link_model u_link (.*);
  // sampled after outputs settle; pulses stick in seen until awaited
  always @(posedge clk) begin
    #0.5;
    seen |= {rq_last, sp_done, variable_sent_notice, variable_received_notice, rd_done};
    if (rq_valid) rq_q.push_back(rq_id);
    if (fr_done) n_fr++;
    if (tx_valid) tx_seen = tx_byte;
    if (rd_data_valid) rd_got = {rd_got[7:0], rd_data};
  end
////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // sel: 0 read done, 1 received, 2 sent, 3 specified done, 4 frame end
  task automatic await(input int sel);
    for (int n = 0; n < 300; n++) begin
      if (seen[sel] === 1'b1) begin
        seen[sel] = 1'b0;
        return;
      end
      @(posedge clk);
      #1;
    end
    mismatches++;
    $display("unexpected at %0t: wait %0d expired", $time, sel);
    close_out;
  endtask
  task cfg(input logic [3:0] ep, input logic [4:0] f);
    @(negedge clk);
    {cfg_we, cfg_ep, cfg_known, cfg_valid, cfg_publish, cfg_spec, cfg_periodic} = {1'b1, ep, f};
    @(negedge clk);
    cfg_we = 1'b0;
  endtask
  task wr(input logic [3:0] ep, input logic [7:0] b);
    @(negedge clk);
    {buffer_write_request, wr_ep, wr_byte, wr_last} = {1'b1, ep, b, 1'b1};
    @(negedge clk);
    buffer_write_request = 1'b0;
    @(negedge clk);
    chk(wr_status, `FBU_ST_OK);
  endtask
  // read machine idle, taken at first edge
  task rd(input logic [3:0] ep, input logic [2:0] st, input logic [15:0] d);
    @(negedge clk);
    {buffer_read_request, rd_ep} = {1'b1, ep};
    @(negedge clk);
    buffer_read_request = 1'b0;
    await(0);
    chk(rd_status, st);
    if (st == `FBU_ST_OK) chk(rd_got, d);
  endtask
  task sp(input logic [15:0] id);
    @(negedge clk);
    {specified_update_request, sp_ep, sp_id, sp_last} = {1'b1, 4'h3, id, 1'b1};
    @(negedge clk);
    specified_update_request = 1'b0;
  endtask
  task fr(input logic [15:0] id, input logic urg);
    @(negedge clk);
    {free_update_request, fr_id, fr_last, fr_urgent} = {1'b1, id, 1'b1, urg};
    @(negedge clk);
    free_update_request = 1'b0;
  endtask
////////////////////////////////////////////////////////////////////////////////
  task t_rx_read;
    cfg(4'h1, 5'h18);
    cfg(4'h6, 5'h10);
    u_link.rx(4'h1, 16'ha53c, 1'b1);
    await(1);
    chk(received_ep, 4'h1);
    rd(4'h1, `FBU_ST_OK, 16'ha53c);
    rd(4'h1, `FBU_ST_OK, 16'ha53c);
    u_link.rx(4'h1, 16'h1111, 1'b0);  // bad frame keeps old value
    rd(4'h1, `FBU_ST_OK, 16'ha53c);
    rd(4'h5, `FBU_ST_UNKNOWN, '0);
    rd(4'h6, `FBU_ST_INVALID, '0);
    $display("test rx_read done");
  endtask
  task t_requests;
    cfg(4'h2, 5'h1d);
    cfg(4'h3, 5'h1f);
    wr(4'h2, 8'h5a);
    wr(4'h3, 8'h33);
    fr(16'h0001, 1'b0);
    fr(16'h0002, 1'b1);
    sp(16'h0777);
    sp(16'h0888);
    await(3);
    chk(sp_status, `FBU_ST_OVERRIDE);
    rq_q = {};
    u_link.tx(4'h3);
    await(4);
    chk(sp_status, `FBU_ST_OK);
    chk(rq_aperiodic, 1'b0);
    @(negedge clk);
    chk(rq_q.size(), 1);
    chk(rq_q[0], 16'h0888);
    rq_q = {};
    n_fr = 0;
    seen = '0;
    u_link.tx(4'h2);
    await(2);
    chk(sent_ep, 4'h2);
    chk(tx_seen, 8'h5a);
    await(4);
    @(negedge clk);
    chk(rq_q.size(), 2);
    chk(rq_q[0], 16'h0002);
    chk(rq_q[1], 16'h0001);
    chk(n_fr, 2);
    chk(rq_aperiodic, 1'b1);
    $display("test requests done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_rx_read;
    t_requests;
    close_out;
  end
endmodule

// File: testbench/fbu_link_model.sv
// far-side link controller model: delivers frames, polls responses
// assumes calls from the bench's main sequence
`timescale 1ns/10ps
module fbu_link_model (
  input  logic       clk,
  output logic       link_rx_valid = 1'b0,
  output logic [3:0] link_rx_ep = '0,
  output logic [7:0] link_rx_byte = '0,
  output logic       link_rx_last = 1'b0,
  output logic       link_rx_ok = 1'b0,
  output logic       link_tx_req = 1'b0,
  output logic [3:0] link_tx_ep = '0
);
  // two-byte frame, high byte first
  task rx(input logic [3:0] ep, input logic [15:0] d, input logic ok);
    for (int i = 1; i >= 0; i--) begin
      @(negedge clk);
      {link_rx_valid, link_rx_ep, link_rx_byte} = {1'b1, ep, d[8*i+:8]};
      {link_rx_last, link_rx_ok} = {i == 0, ok};
    end
    @(negedge clk);
    link_rx_valid = 1'b0;
    link_rx_byte = ~link_rx_byte;  // stale lane must not look like data
  endtask
  // one poll, only while emission idle
  task tx(input logic [3:0] ep);
    @(negedge clk);
    {link_tx_req, link_tx_ep} = {1'b1, ep};
    @(negedge clk);
    link_tx_req = 1'b0;
  endtask
endmodule

// File: verilog/fbu_link_entity.v
// link entity: variable buffers, read/write service, notices, update requests
// assumes a link controller that streams one byte or identifier per cycle
`timescale 1ns/10ps
`include "fbu_defines.vh"

// Overview of operation
// - reading leaves the stored value intact
// - read ends with ok, unknown, invalid or conflict
// - success returns latest value, data else meaningless
// - each buffer holds at most 128 octets
// - conflict only on real concurrent bank access
// - exactly one completion per read request
// - sent notice with endpoint after each emission
// - good reception stored, then received notice
// - endpoint never both specified and free service
// - free urgent or normal, specified always urgent
// - per endpoint list, new request overrides old
// - specified list periodic or aperiodic by configuration
// - free requests queued urgent or normal dynamically
// - free list rides first eligible published response
// - one frame, one completion per free request
// - request frame carries at most 64 identifiers
// - one free request never split across frames
// - write replaces value, oversize write fails
module fbu_link_entity (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire                  cfg_we,
  input  wire [`FBU_EP_W-1:0]  cfg_ep,
  input  wire                  cfg_known,
  input  wire                  cfg_valid,
  input  wire                  cfg_publish,
  input  wire                  cfg_spec,
  input  wire                  cfg_periodic,
  input  wire                  buffer_write_request,
  input  wire [`FBU_EP_W-1:0]  wr_ep,
  input  wire [7:0]            wr_byte,
  input  wire                  wr_last,
  output reg                   wr_done,
  output reg  [2:0]            wr_status,
  input  wire                  buffer_read_request,
  input  wire [`FBU_EP_W-1:0]  rd_ep,
  output wire                  rd_ready,
  output reg                   rd_data_valid,
  output reg  [7:0]            rd_data,
  output reg                   rd_done,
  output reg  [2:0]            rd_status,
  input  wire                  link_rx_valid,
  input  wire [`FBU_EP_W-1:0]  link_rx_ep,
  input  wire [7:0]            link_rx_byte,
  input  wire                  link_rx_last,
  input  wire                  link_rx_ok,
  output reg                   variable_received_notice,
  output reg  [`FBU_EP_W-1:0]  received_ep,
  input  wire                  link_tx_req,
  input  wire [`FBU_EP_W-1:0]  link_tx_ep,
  output reg                   tx_valid,
  output reg  [7:0]            tx_byte,
  output reg                   tx_last,
  output reg                   tx_none,
  output reg                   variable_sent_notice,
  output reg  [`FBU_EP_W-1:0]  sent_ep,
  output reg                   rq_valid,
  output reg  [`FBU_ID_W-1:0]  rq_id,
  output reg                   rq_last,
  output reg                   rq_aperiodic,
  input  wire                  specified_update_request,
  input  wire [`FBU_EP_W-1:0]  sp_ep,
  input  wire [`FBU_ID_W-1:0]  sp_id,
  input  wire                  sp_last,
  output wire                  sp_ready,
  output reg                   sp_done,
  output reg  [`FBU_EP_W-1:0]  sp_done_ep,
  output reg  [2:0]            sp_status,
  input  wire                  free_update_request,
  input  wire [`FBU_ID_W-1:0]  fr_id,
  input  wire                  fr_last,
  input  wire                  fr_urgent,
  output wire                  fr_ready,
  output reg                   fr_done,
  output reg                   fr_done_urgent,
  output reg  [2:0]            fr_status
);

  localparam RD_IDLE = 2'b01;
  localparam RD_DAT  = 2'b10;
  localparam TX_IDLE = 3'b001;
  localparam TX_DAT  = 3'b010;
  localparam TX_REQ  = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // configuration table and buffer bookkeeping

  reg [`FBU_EPS-1:0] cfg_known_reg;
  reg [`FBU_EPS-1:0] cfg_valid_reg;
  reg [`FBU_EPS-1:0] cfg_pub_reg;
  reg [`FBU_EPS-1:0] cfg_spec_reg;
  reg [`FBU_EPS-1:0] cfg_per_reg;
  reg [`FBU_EPS-1:0] bank_reg;
  reg [7:0]          len_reg [0:`FBU_EPS-1];
  reg [7:0]          mem [0:(1<<`FBU_MEM_AW)-1];
  reg [`FBU_ID_W-1:0] splist [0:(1<<`FBU_LST_AW)-1];
  reg [6:0]          sp_len_reg [0:`FBU_EPS-1];
  reg [`FBU_EPS-1:0] sp_pend_reg;
  integer            i;

  reg [7:0]           rx_cnt_reg;
  reg                 rx_err_reg;
  reg [7:0]           wr_cnt_reg;
  reg [2:0]           wr_err_reg;
  reg [2:0]           wr_chk;
  reg [1:0]           rd_state_reg;
  reg [`FBU_EP_W-1:0] rd_ep_reg;
  reg                 rd_bank_reg;
  reg [6:0]           rd_idx_reg;
  reg                 rd_conf_reg;
  reg [2:0]           tx_state_reg;
  reg [`FBU_EP_W-1:0] tx_ep_reg;
  reg                 tx_bank_reg;
  reg [6:0]           tx_idx_reg;
  reg                 tx_sp_reg;
  reg                 tx_fr_reg;
  reg                 sp_act_reg;
  reg [6:0]           sp_cnt_reg;
  reg [6:0]           fr_stage_reg;
  reg                 fr_ovf_reg;

  wire [`FBU_ID_W:0] u_head;
  wire [`FBU_ID_W:0] n_head;
  wire               u_empty;
  wire               n_empty;
  wire [6:0]         u_cnt;
  wire [6:0]         n_cnt;

  // double banks keep the readable copy stable
  wire rx_elig = cfg_known_reg[link_rx_ep] & cfg_valid_reg[link_rx_ep]
               & ~cfg_pub_reg[link_rx_ep];
  wire rx_we   = link_rx_valid & rx_elig & (rx_cnt_reg < `FBU_BUF_MAX);
  wire [`FBU_MEM_AW-1:0] rx_addr = {link_rx_ep, ~bank_reg[link_rx_ep], rx_cnt_reg[6:0]};
  wire [2:0] wr_err_next = (wr_err_reg != `FBU_ST_OK) ? wr_err_reg : wr_chk;
  wire wr_we = buffer_write_request & (wr_err_next == `FBU_ST_OK);
  wire [`FBU_MEM_AW-1:0] wr_addr = {wr_ep, ~bank_reg[wr_ep], wr_cnt_reg[6:0]};
  wire rd_hit = (rd_state_reg == RD_DAT) & rx_we & (link_rx_ep == rd_ep_reg)
              & (~bank_reg[link_rx_ep] == rd_bank_reg);
  wire [7:0] q_total  = {1'b0, u_cnt} + {1'b0, n_cnt};
  wire [7:0] fr_total = q_total + {1'b0, fr_stage_reg};
  wire fr_room = (fr_total < `FBU_QFRAME);
  wire in_sp_req = (tx_state_reg == TX_REQ) & tx_sp_reg;
  wire in_fr_req = (tx_state_reg == TX_REQ) & tx_fr_reg;
  wire fr_beat = free_update_request & fr_ready;
  wire fr_fail = fr_beat & fr_last & (~fr_room | fr_ovf_reg);
  wire pop_u = in_fr_req & ~u_empty;
  wire pop_n = in_fr_req & u_empty;
  wire [`FBU_ID_W:0] fr_head = u_empty ? n_head : u_head;

  assign rd_ready = (rd_state_reg == RD_IDLE);
  assign sp_ready = ~in_sp_req;
  assign fr_ready = ~in_fr_req;

  // first write error sticks until the last beat
  always @* begin
    wr_chk = `FBU_ST_OK;
    if (!cfg_known_reg[wr_ep] || !cfg_pub_reg[wr_ep])
      wr_chk = `FBU_ST_UNKNOWN;
    else if (!cfg_valid_reg[wr_ep])
      wr_chk = `FBU_ST_INVALID;
    else if (wr_cnt_reg >= `FBU_BUF_MAX)
      wr_chk = `FBU_ST_SIZE;
    else if (tx_state_reg == TX_DAT && tx_ep_reg == wr_ep
             && tx_bank_reg == ~bank_reg[wr_ep])
      wr_chk = `FBU_ST_CONFLICT;
  end

  always @(posedge clk) begin
    if (rx_we)
      mem[rx_addr] <= link_rx_byte;
    if (wr_we)
      mem[wr_addr] <= wr_byte;
    if (specified_update_request && sp_ready && cfg_known_reg[sp_ep]
        && cfg_valid_reg[sp_ep] && cfg_spec_reg[sp_ep] && sp_cnt_reg < `FBU_LIST_MAX)
      splist[{sp_ep, sp_cnt_reg[5:0]}] <= sp_id;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, reception and user writes

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_known_reg <= 16'h0000;
      cfg_valid_reg <= 16'h0000;
      cfg_pub_reg   <= 16'h0000;
      cfg_spec_reg  <= 16'h0000;
      cfg_per_reg   <= 16'h0000;
      bank_reg      <= 16'h0000;
      for (i = 0; i < `FBU_EPS; i = i + 1)
        len_reg[i] <= 8'h00;
      rx_cnt_reg <= 8'h00;
      rx_err_reg <= 1'b0;
      wr_cnt_reg <= 8'h00;
      wr_err_reg <= `FBU_ST_OK;
      wr_done    <= 1'b0;
      wr_status  <= `FBU_ST_OK;
      variable_received_notice <= 1'b0;
      received_ep <= 4'h0;
    end else begin
      wr_done <= 1'b0;
      variable_received_notice <= 1'b0;
      if (cfg_we) begin
        cfg_known_reg[cfg_ep] <= cfg_known;
        cfg_valid_reg[cfg_ep] <= cfg_valid;
        cfg_pub_reg[cfg_ep]   <= cfg_publish;
        cfg_spec_reg[cfg_ep]  <= cfg_spec & cfg_publish;  // free use needs !spec
        cfg_per_reg[cfg_ep]   <= cfg_periodic;
      end
      if (link_rx_valid) begin
        if (link_rx_last) begin
          rx_cnt_reg <= 8'h00;
          rx_err_reg <= 1'b0;
          if (rx_elig && link_rx_ok && !rx_err_reg && rx_cnt_reg < `FBU_BUF_MAX) begin
            bank_reg[link_rx_ep] <= ~bank_reg[link_rx_ep];
            len_reg[link_rx_ep]  <= rx_cnt_reg + 8'h01;
            variable_received_notice <= 1'b1;
            received_ep <= link_rx_ep;
          end
        end else begin
          if (rx_cnt_reg >= `FBU_BUF_MAX)
            rx_err_reg <= 1'b1;
          else
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
        end
      end
      if (buffer_write_request) begin
        if (wr_last) begin
          wr_cnt_reg <= 8'h00;
          wr_err_reg <= `FBU_ST_OK;
          wr_done    <= 1'b1;
          wr_status  <= wr_err_next;
          if (wr_err_next == `FBU_ST_OK) begin
            bank_reg[wr_ep] <= ~bank_reg[wr_ep];
            len_reg[wr_ep]  <= wr_cnt_reg + 8'h01;
          end
        end else begin
          wr_err_reg <= wr_err_next;
          if (wr_cnt_reg < `FBU_BUF_MAX)
            wr_cnt_reg <= wr_cnt_reg + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user buffer read

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_state_reg  <= RD_IDLE;
      rd_ep_reg     <= 4'h0;
      rd_bank_reg   <= 1'b0;
      rd_idx_reg    <= 7'h00;
      rd_conf_reg   <= 1'b0;
      rd_data_valid <= 1'b0;
      rd_data       <= 8'h00;
      rd_done       <= 1'b0;
      rd_status     <= `FBU_ST_OK;
    end else begin
      rd_data_valid <= 1'b0;
      rd_done       <= 1'b0;
      case (rd_state_reg)
        RD_IDLE: begin
          if (buffer_read_request) begin
            rd_ep_reg   <= rd_ep;
            rd_bank_reg <= bank_reg[rd_ep];
            rd_idx_reg  <= 7'h00;
            rd_conf_reg <= 1'b0;
            if (!cfg_known_reg[rd_ep] || cfg_pub_reg[rd_ep]) begin
              rd_done   <= 1'b1;
              rd_status <= `FBU_ST_UNKNOWN;
            end else if (!cfg_valid_reg[rd_ep]) begin
              rd_done   <= 1'b1;
              rd_status <= `FBU_ST_INVALID;
            end else if (len_reg[rd_ep] == 8'h00) begin
              rd_done   <= 1'b1;
              rd_status <= `FBU_ST_OK;
            end else begin
              rd_state_reg <= RD_DAT;
            end
          end
        end
        RD_DAT: begin
          // reads never swap banks, so rereads match
          rd_data       <= mem[{rd_ep_reg, rd_bank_reg, rd_idx_reg}];
          rd_data_valid <= 1'b1;
          rd_idx_reg    <= rd_idx_reg + 7'h01;
          if (rd_hit)
            rd_conf_reg <= 1'b1;
          if ({1'b0, rd_idx_reg} == len_reg[rd_ep_reg] - 8'h01) begin
            rd_done      <= 1'b1;
            rd_status    <= (rd_conf_reg | rd_hit) ? `FBU_ST_CONFLICT : `FBU_ST_OK;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // emission, request frame, specified and free update requests

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg <= TX_IDLE;
      tx_ep_reg    <= 4'h0;
      tx_bank_reg  <= 1'b0;
      tx_idx_reg   <= 7'h00;
      tx_sp_reg    <= 1'b0;
      tx_fr_reg    <= 1'b0;
      tx_valid     <= 1'b0;
      tx_byte      <= 8'h00;
      tx_last      <= 1'b0;
      tx_none      <= 1'b0;
      variable_sent_notice <= 1'b0;
      sent_ep      <= 4'h0;
      rq_valid     <= 1'b0;
      rq_id        <= 16'h0000;
      rq_last      <= 1'b0;
      rq_aperiodic <= 1'b0;
      sp_pend_reg  <= 16'h0000;
      for (i = 0; i < `FBU_EPS; i = i + 1)
        sp_len_reg[i] <= 7'h00;
      sp_act_reg   <= 1'b0;
      sp_cnt_reg   <= 7'h00;
      sp_done      <= 1'b0;
      sp_done_ep   <= 4'h0;
      sp_status    <= `FBU_ST_OK;
      fr_stage_reg <= 7'h00;
      fr_ovf_reg   <= 1'b0;
      fr_done      <= 1'b0;
      fr_done_urgent <= 1'b0;
      fr_status    <= `FBU_ST_OK;
    end else begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      tx_none  <= 1'b0;
      variable_sent_notice <= 1'b0;
      rq_valid <= 1'b0;
      rq_last  <= 1'b0;
      sp_done  <= 1'b0;
      fr_done  <= 1'b0;
      case (tx_state_reg)
        TX_IDLE: begin
          if (link_tx_req) begin
            tx_ep_reg   <= link_tx_ep;
            tx_bank_reg <= bank_reg[link_tx_ep];
            tx_idx_reg  <= 7'h00;
            tx_sp_reg   <= sp_pend_reg[link_tx_ep];
            // free list goes out on the first periodic non-specified response
            tx_fr_reg   <= ~cfg_spec_reg[link_tx_ep] & cfg_per_reg[link_tx_ep]
                         & (q_total != 8'h00);
            rq_aperiodic <= cfg_spec_reg[link_tx_ep] ? ~cfg_per_reg[link_tx_ep]
                                                     : 1'b1;
            if (cfg_known_reg[link_tx_ep] && cfg_valid_reg[link_tx_ep]
                && cfg_pub_reg[link_tx_ep] && len_reg[link_tx_ep] != 8'h00)
              tx_state_reg <= TX_DAT;
            else
              tx_none <= 1'b1;
          end
        end
        TX_DAT: begin
          tx_byte    <= mem[{tx_ep_reg, tx_bank_reg, tx_idx_reg}];
          tx_valid   <= 1'b1;
          tx_idx_reg <= tx_idx_reg + 7'h01;
          if ({1'b0, tx_idx_reg} == len_reg[tx_ep_reg] - 8'h01) begin
            tx_last <= 1'b1;
            variable_sent_notice <= 1'b1;
            sent_ep <= tx_ep_reg;
            tx_idx_reg <= 7'h00;
            tx_state_reg <= (tx_sp_reg | tx_fr_reg) ? TX_REQ : TX_IDLE;
          end
        end
        TX_REQ: begin
          rq_valid <= 1'b1;
          if (tx_sp_reg) begin
            rq_id <= splist[{tx_ep_reg, tx_idx_reg[5:0]}];
            tx_idx_reg <= tx_idx_reg + 7'h01;
            if (tx_idx_reg == sp_len_reg[tx_ep_reg] - 7'h01) begin
              rq_last <= 1'b1;
              sp_pend_reg[tx_ep_reg] <= 1'b0;
              sp_done    <= 1'b1;
              sp_done_ep <= tx_ep_reg;
              sp_status  <= `FBU_ST_OK;
              tx_state_reg <= TX_IDLE;
            end
          end else begin
            // whole queue fits one frame, so no request is ever split
            rq_id <= fr_head[`FBU_ID_W-1:0];
            if (fr_head[`FBU_ID_W]) begin
              fr_done        <= 1'b1;
              fr_done_urgent <= ~u_empty;
              fr_status      <= `FBU_ST_OK;
            end
            if (q_total == 8'h01) begin
              rq_last <= 1'b1;
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
      if (specified_update_request && sp_ready) begin
        if (cfg_known_reg[sp_ep] && cfg_valid_reg[sp_ep] && cfg_spec_reg[sp_ep]) begin
          if (!sp_act_reg && sp_pend_reg[sp_ep]) begin
            sp_done    <= 1'b1;
            sp_done_ep <= sp_ep;
            sp_status  <= `FBU_ST_OVERRIDE;
            sp_pend_reg[sp_ep] <= 1'b0;
          end
          if (sp_cnt_reg < `FBU_LIST_MAX)
            sp_cnt_reg <= sp_cnt_reg + 7'h01;
          if (sp_last) begin
            sp_pend_reg[sp_ep] <= 1'b1;
            sp_len_reg[sp_ep]  <= (sp_cnt_reg < `FBU_LIST_MAX) ? sp_cnt_reg + 7'h01
                                                               : `FBU_LIST_MAX;
          end
        end else if (sp_last) begin
          sp_done    <= 1'b1;
          sp_done_ep <= sp_ep;
          sp_status  <= `FBU_ST_UNKNOWN;
        end
        sp_act_reg <= ~sp_last;
        if (sp_last)
          sp_cnt_reg <= 7'h00;
      end
      if (fr_beat) begin
        if (fr_last) begin
          fr_stage_reg <= 7'h00;
          fr_ovf_reg   <= 1'b0;
          if (fr_fail) begin
            fr_done        <= 1'b1;
            fr_done_urgent <= fr_urgent;
            fr_status      <= `FBU_ST_QFULL;
          end
        end else if (!fr_room) begin
          fr_ovf_reg <= 1'b1;
        end else begin
          fr_stage_reg <= fr_stage_reg + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // urgent and normal free request queues

  fbu_req_queue #(.DW(`FBU_ID_W + 1)) u_urgent_q (
    .clk       (clk),
    .rstn      (rstn),
    .push      (fr_beat & fr_urgent & fr_room & ~fr_ovf_reg),
    .push_data ({fr_last, fr_id}),
    .commit    (fr_beat & fr_last & fr_urgent & ~fr_fail),
    .abort     (fr_fail),
    .pop       (pop_u),
    .head      (u_head),
    .empty     (u_empty),
    .count     (u_cnt)
  );

  fbu_req_queue #(.DW(`FBU_ID_W + 1)) u_normal_q (
    .clk       (clk),
    .rstn      (rstn),
    .push      (fr_beat & ~fr_urgent & fr_room & ~fr_ovf_reg),
    .push_data ({fr_last, fr_id}),
    .commit    (fr_beat & fr_last & ~fr_urgent & ~fr_fail),
    .abort     (fr_fail),
    .pop       (pop_n),
    .head      (n_head),
    .empty     (n_empty),
    .count     (n_cnt)
  );

endmodule

// File: verilog/fbu_req_queue.v
// free request queue: staged pushes, committed per request, popped by the frame
// assumes the caller never pushes beyond the depth and holds commit/abort apart
`timescale 1ns/10ps
`include "fbu_defines.vh"

module fbu_req_queue #(
  parameter DW = 17
) (
  input  wire          clk,
  input  wire          rstn,
  input  wire          push,
  input  wire [DW-1:0] push_data,
  input  wire          commit,
  input  wire          abort,
  input  wire          pop,
  output wire [DW-1:0] head,
  output wire          empty,
  output wire [6:0]    count
);

  reg [DW-1:0] mem [0:`FBU_QDEPTH-1];
  reg [6:0]    wp_reg;
  reg [6:0]    cp_reg;
  reg [6:0]    rp_reg;

  // only committed entries leave, never a half-staged list
  assign count = cp_reg - rp_reg;
  assign empty = (count == 7'h00);
  assign head  = mem[rp_reg[5:0]];

  always @(posedge clk) begin
    if (push)
      mem[wp_reg[5:0]] <= push_data;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= 7'h00;
      cp_reg <= 7'h00;
      rp_reg <= 7'h00;
    end else begin
      if (abort)
        wp_reg <= cp_reg;
      else if (push)
        wp_reg <= wp_reg + 7'h01;
      if (commit)
        cp_reg <= push ? wp_reg + 7'h01 : wp_reg;
      if (pop)
        rp_reg <= rp_reg + 7'h01;
    end
  end

endmodule
